// File: design/shunt_bus_conversion_sequencer.sv
/*
  Conversion sequencer for a shunt and bus voltage monitor, with background current and
  power arithmetic, an AHB-Lite register slave and a masked level interrupt.
  Assumes an external ADC handshake on hclk (start pulse, done pulse with data) and an
  asynchronous convert trigger pin.
*/
// Overview of operation
// - Mode 101 converts shunt repeatedly, averaging the shunt averaging field count.
// - With the bus mode bit set, each shunt set is followed by a bus set using the bus averaging count.
// - Mode codes offer shunt only or bus only, continuous or triggered.
// - Current and power are computed alongside the next conversion, adding no time.
// - Leaving power-down waits 40 us before conversions resume.
// - ADC-off mode halts all conversion activity.
// - Every write of a triggered mode launches one single-shot conversion.
// - Result registers always readable and hold the last completed result.
// - Ready flag sets only after conversions, averaging and multiplications finish.
// - Configuration writes clear ready, except power-down or ADC-off writes.
// - Reading the status register clears ready.
// - A single shot launched by the trigger pin clears ready.
// - Shunt gain selects one, two, four or eight times the 40 mV range.
// - Bus range selects 16 V or 32 V full scale.
// - Shunt and bus resolution and averaging fields are separate.
// - With 128-sample averaging shunt and bus samples may lie 68 ms apart.
// - Reset gives 12-bit, 320 mV, 32 V range, continuous both channels.
// - Current and power are zero while calibration is zero.
`timescale 1ns/1ps
module shunt_bus_conversion_sequencer
  import shunt_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic conv_trigger,
  output logic adc_start,
  output logic adc_chan,
  output logic adc_power_en,
  output logic [1:0] adc_res,
  input wire logic adc_done,
  input wire logic [15:0] adc_data,
  output logic [1:0] shunt_gain_setting,
  output logic bus_range_sel
);

  state_t s_reg;
  state_t s_next;

  logic [2:0] mode;
  logic halt;
  logic cfg_wr;
  logic clr_ready;
  logic trig_edge;
  logic first_chan;
  logic [2:0] shift;
  logic [7:0] nsamp;
  logic [23:0] acc_new;
  logic [23:0] avg;
  logic signed [32:0] prod_c;
  logic signed [32:0] cur_wide;
  logic [15:0] cur;
  logic [16:0] cur_mag;
  logic [32:0] prod_p;
  logic [32:0] pow_q;
  logic ovf;

  // Samples per result: 2^n when bit 3 is set, else one sample
  function automatic logic [2:0] avg_shift(input logic [3:0] field);
    avg_shift = field[3] ? field[2:0] : 3'h0;
  endfunction

  // Resolution code handed to the ADC; averaging runs at full resolution
  function automatic logic [1:0] res_code(input logic [3:0] field);
    res_code = field[3] ? 2'h3 : field[1:0];
  endfunction

  function automatic logic [15:0] sat_s16(input logic signed [32:0] v);
    if (v > 33'sh000007fff) begin
      sat_s16 = 16'h7fff;
    end else if (v < -33'sh000008000) begin
      sat_s16 = 16'h8000;
    end else begin
      sat_s16 = v[15:0];
    end
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.adc_start = 1'b0;
    s_next.hreadyout = 1'b1;
    s_next.hresp = 1'b0;
    s_next.wr_pend = 1'b0;
    s_next.trig_s1 = conv_trigger;
    s_next.trig_s2 = s_reg.trig_s1;
    s_next.trig_prev = s_reg.trig_s2;
    cfg_wr = 1'b0;
    clr_ready = 1'b0;
    shift = 3'h0;
    nsamp = 8'h01;
    acc_new = 24'h000000;
    avg = 24'h000000;
    prod_c = 33'sh000000000;
    cur_wide = 33'sh000000000;
    cur = 16'h0000;
    cur_mag = 17'h00000;
    prod_p = 33'h000000000;
    pow_q = 33'h000000000;
    ovf = 1'b0;

    // Bus data phase of a write
    if (s_reg.wr_pend) begin
      case (s_reg.wr_addr)
        OFF_CONFIG: begin
          s_next.cfg = hwdata[CFG_W-1:0];
          cfg_wr = 1'b1;
          if (hwdata[CFG_MODE_POS +: 3] != MODE_PDOWN &&
              hwdata[CFG_MODE_POS +: 3] != MODE_ADC_OFF) begin
            clr_ready = 1'b1;
          end
          if (!hwdata[CFG_MODE_POS + MODE_CONT_BIT] &&
              hwdata[CFG_MODE_POS +: 3] != MODE_PDOWN) begin
            s_next.oneshot = 1'b1;
          end
        end
        OFF_CAL: s_next.cal = hwdata[15:0];
        OFF_IRQ_STAT: s_next.irq_stat = s_reg.irq_stat & ~hwdata[1:0];
        OFF_IRQ_MASK: s_next.irq_mask = hwdata[1:0];
        default: ;
      endcase
    end

    // Bus address phase; read data is registered for the data phase
    s_next.hrdata = 32'h00000000;
    if (hsel && htrans[1] && hready) begin
      s_next.wr_pend = hwrite && (haddr[31:8] == 24'h000000);
      s_next.wr_addr = haddr[7:0];
      if (!hwrite && haddr[31:8] == 24'h000000) begin
        case (haddr[7:0])
          OFF_CONFIG: s_next.hrdata = {18'h00000, s_reg.cfg};
          OFF_SHUNT: s_next.hrdata = {16'h0000, s_reg.shunt_val};
          OFF_BUS: s_next.hrdata = {16'h0000, s_reg.bus_val};
          OFF_POWER: s_next.hrdata = {16'h0000, s_reg.pow_val};
          OFF_CURRENT: s_next.hrdata = {16'h0000, s_reg.cur_val};
          OFF_CAL: s_next.hrdata = {16'h0000, s_reg.cal};
          OFF_STATUS: begin
            s_next.hrdata = {30'h00000000,
                             s_reg.seq != SEQ_IDLE || s_reg.calc_pend, s_reg.ready};
            clr_ready = 1'b1;
          end
          OFF_IRQ_STAT: s_next.hrdata = {30'h00000000, s_reg.irq_stat};
          OFF_IRQ_MASK: s_next.hrdata = {30'h00000000, s_reg.irq_mask};
          default: s_next.hrdata = 32'h00000000;
        endcase
      end
    end

    mode = s_next.cfg[CFG_MODE_POS +: 3];
    halt = (mode == MODE_PDOWN) || (mode == MODE_ADC_OFF);
    first_chan = !mode[MODE_SHUNT_BIT];

    // Trigger pin launches a single shot in triggered modes
    trig_edge = s_reg.trig_s2 && !s_reg.trig_prev;
    if (trig_edge && !halt && !mode[MODE_CONT_BIT]) begin
      s_next.oneshot = 1'b1;
      clr_ready = 1'b1;
    end

    if (clr_ready) begin
      s_next.ready = 1'b0;
    end

    // Background arithmetic, one cycle, while the next set already runs
    if (s_reg.calc_pend) begin
      s_next.calc_pend = 1'b0;
      if (s_reg.cal == 16'h0000) begin
        s_next.cur_val = 16'h0000;
        s_next.pow_val = 16'h0000;
      end else begin
        prod_c = $signed(s_reg.shunt_val) * $signed({1'b0, s_reg.cal});
        cur_wide = prod_c >>> CURRENT_SHIFT;
        cur = sat_s16(cur_wide);
        cur_mag = cur[15] ? (17'h00000 - {1'b1, cur}) : {1'b0, cur};
        prod_p = cur_mag * s_reg.bus_val;
        pow_q = prod_p / POWER_DIV;
        ovf = (cur_wide > 33'sh000007fff) || (cur_wide < -33'sh000008000) ||
              (pow_q > 33'h00000ffff);
        s_next.cur_val = cur;
        s_next.pow_val = (pow_q > 33'h00000ffff) ? 16'hffff : pow_q[15:0];
      end
      s_next.ready = 1'b1;
      s_next.irq_stat[IRQ_DONE_BIT] = 1'b1;
      if (ovf) begin
        s_next.irq_stat[IRQ_OVF_BIT] = 1'b1;
      end
    end

    // Conversion sequencer
    s_next.adc_power_en = (mode != MODE_PDOWN);
    if (mode == MODE_PDOWN) begin
      s_next.pd_seen = 1'b1;
    end
    if (halt || cfg_wr) begin
      s_next.seq = SEQ_IDLE;
      if (halt) begin
        s_next.oneshot = 1'b0;
      end
    end else begin
      case (s_reg.seq)
        SEQ_IDLE: begin
          if (s_reg.pd_seen) begin
            s_next.seq = SEQ_WAKE;
            s_next.wait_cnt = 10'h000;
          end else if (mode[MODE_CONT_BIT] || s_next.oneshot) begin
            s_next.chan = first_chan;
            s_next.cnt = 8'h00;
            s_next.acc = 24'h000000;
            s_next.seq = SEQ_START;
          end
        end
        SEQ_WAKE: begin
          if (s_reg.wait_cnt == RECOVER_LAST) begin
            s_next.pd_seen = 1'b0;
            s_next.seq = SEQ_IDLE;
          end else begin
            s_next.wait_cnt = s_reg.wait_cnt + 10'h001;
          end
        end
        SEQ_START: begin
          s_next.adc_start = 1'b1;
          s_next.seq = SEQ_WAIT;
        end
        SEQ_WAIT: begin
          if (adc_done) begin
            shift = s_reg.chan ? avg_shift(s_reg.cfg[CFG_BAVG_POS +: 4]) :
                                 avg_shift(s_reg.cfg[CFG_SAVG_POS +: 4]);
            nsamp = 8'h01 << shift;
            acc_new = s_reg.acc + (s_reg.chan ? {8'h00, adc_data} :
                                   {{8{adc_data[15]}}, adc_data});
            if (s_reg.cnt == nsamp - 8'h01) begin
              avg = $signed(acc_new) >>> shift;
              if (s_reg.chan) begin
                s_next.bus_val = avg[15:0];
              end else begin
                s_next.shunt_val = avg[15:0];
              end
              s_next.cnt = 8'h00;
              s_next.acc = 24'h000000;
              if (!s_reg.chan && mode[MODE_BUS_BIT]) begin
                s_next.chan = 1'b1;
                s_next.seq = SEQ_START;
              end else begin
                s_next.calc_pend = 1'b1;
                if (mode[MODE_CONT_BIT]) begin
                  s_next.chan = first_chan;
                  s_next.seq = SEQ_START;
                end else begin
                  s_next.oneshot = 1'b0;
                  s_next.seq = SEQ_IDLE;
                end
              end
            end else begin
              s_next.acc = acc_new;
              s_next.cnt = s_reg.cnt + 8'h01;
              s_next.seq = SEQ_START;
            end
          end
        end
        default: s_next.seq = SEQ_IDLE;
      endcase
    end
    s_next.adc_res = s_next.chan ? res_code(s_next.cfg[CFG_BAVG_POS +: 4]) :
                                   res_code(s_next.cfg[CFG_SAVG_POS +: 4]);

    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.cfg <= CFG_RESET;
      s_reg.hreadyout <= 1'b1;
      s_reg.adc_power_en <= 1'b1;
      s_reg.adc_res <= 2'h3;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.hreadyout;
  assign hresp = s_reg.hresp;
  assign hrdata = s_reg.hrdata;
  assign irq = s_reg.irq;
  assign adc_start = s_reg.adc_start;
  assign adc_chan = s_reg.chan;
  assign adc_power_en = s_reg.adc_power_en;
  assign adc_res = s_reg.adc_res;
  assign shunt_gain_setting = s_reg.cfg[CFG_GAIN_POS +: 2];
  assign bus_range_sel = s_reg.cfg[CFG_BRNG_POS];

endmodule

// File: design/shunt_seq_pkg.sv
/*
  Constants, register map and state types for the shunt and bus conversion sequencer.
  Assumes a 25 MHz clock and 32-bit AHB-Lite register access, one word per register.
*/
package shunt_seq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_SHUNT = 8'h04;
  localparam logic [7:0] OFF_BUS = 8'h08;
  localparam logic [7:0] OFF_POWER = 8'h0c;
  localparam logic [7:0] OFF_CURRENT = 8'h10;
  localparam logic [7:0] OFF_CAL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  // Configuration field layout
  localparam int CFG_W = 14;
  localparam int CFG_MODE_POS = 0;
  localparam int CFG_SAVG_POS = 3;
  localparam int CFG_BAVG_POS = 7;
  localparam int CFG_GAIN_POS = 11;
  localparam int CFG_BRNG_POS = 13;
  localparam logic [CFG_W-1:0] CFG_RESET = 14'h399f;

  // Mode field codes and bits
  localparam logic [2:0] MODE_PDOWN = 3'h0;
  localparam logic [2:0] MODE_ADC_OFF = 3'h4;
  localparam int MODE_SHUNT_BIT = 0;
  localparam int MODE_BUS_BIT = 1;
  localparam int MODE_CONT_BIT = 2;

  // Status and interrupt bits
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;

  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int RECOVER_NS = 40000;
  localparam int RECOVER_CYCLES = (RECOVER_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [9:0] RECOVER_LAST = 10'(RECOVER_CYCLES - 1);

  // Arithmetic scaling
  localparam int CURRENT_SHIFT = 12;
  localparam logic [32:0] POWER_DIV = 33'h000001388;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAKE, SEQ_START, SEQ_WAIT} seq_t;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [15:0] cal;
    logic [15:0] shunt_val;
    logic [15:0] bus_val;
    logic [15:0] cur_val;
    logic [15:0] pow_val;
    logic ready;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    seq_t seq;
    logic chan;
    logic [7:0] cnt;
    logic [23:0] acc;
    logic [9:0] wait_cnt;
    logic pd_seen;
    logic oneshot;
    logic calc_pend;
    logic adc_start;
    logic adc_power_en;
    logic [1:0] adc_res;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic trig_s1;
    logic trig_s2;
    logic trig_prev;
  } state_t;

endpackage

// File: tb/adc_model.sv
/* Behavioural ADC answering the sequencer's start pulses.
   Assumes one clock shared with the sequencer; lat sets the answer delay. */
`timescale 1ns/1ps
module adc_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic chan,
  input wire logic [3:0] lat,
  input wire logic [15:0] shunt_v,
  input wire logic [15:0] bus_v,
  output logic done,
  output logic [15:0] data
);
  logic [4:0] cnt;
  logic ch;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 5'h0;
      ch <= 1'b0;
      done <= 1'b0;
      data <= 16'h0;
    end else begin
      done <= 1'b0;
      // Data is meaningless outside the done cycle
      data <= ~data;
      if (start) begin
        cnt <= {1'b0, lat} + 5'h1;
        ch <= chan;
      end else if (cnt == 5'h1) begin
        cnt <= 5'h0;
        done <= 1'b1;
        data <= ch ? bus_v : shunt_v;
      end else if (cnt != 5'h0) begin
        cnt <= cnt - 5'h1;
      end
    end
  end
endmodule

// File: tb/seq_props.sv
/* Port assertions for the conversion sequencer.
   Bound to every instance of the sequencer; single clock domain. */
`timescale 1ns/1ps
module seq_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic adc_start,
  input wire logic adc_power_en,
  input wire logic [1:0] shunt_gain_setting,
  input wire logic bus_range_sel
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_cfg;
  logic [2:0] cfg_d;
  logic [9:0] pd_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_cfg <= 1'b0;
      cfg_d <= 3'h0;
      pd_cnt <= 10'h3ff;
    end else begin
      wr_cfg <= hsel && htrans[1] && hwrite && hready && haddr == 32'h0;
      cfg_d <= wr_cfg ? hwdata[13:11] : cfg_d;
      pd_cnt <= !adc_power_en ? 10'h0 : pd_cnt + {9'h0, pd_cnt != 10'h3ff};
    end
  end
  property p_pulse; adc_start |=> !adc_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("wait or error response");
  property p_rdata; !(hsel && htrans[1] && !hwrite && hready) |=> hrdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside data phase");
  property p_cfg; wr_cfg |=> ##[0:1] {bus_range_sel, shunt_gain_setting} == cfg_d; endproperty
  a_cfg: assert property (p_cfg) else $error("gain or range not from config");
  property p_off; wr_cfg && hwdata[2:0] == 3'h4 |=> ##2 !adc_start [*8]; endproperty
  a_off: assert property (p_off) else $error("conversion while off");
  property p_pd; wr_cfg && hwdata[2:0] == 3'h0 |=> ##1 !adc_power_en; endproperty
  a_pd: assert property (p_pd) else $error("power kept in power-down");
  property p_trig;
    wr_cfg && adc_power_en && hwdata[2] == 1'b0 && hwdata[1:0] != 2'h0 |-> ##[2:8] adc_start;
  endproperty
  a_trig: assert property (p_trig) else $error("triggered write without shot");
  property p_wake; adc_start |-> pd_cnt >= 10'd999; endproperty
  a_wake: assert property (p_wake) else $error("start too soon after power-down");
endmodule
bind shunt_bus_conversion_sequencer seq_props i_seq_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .adc_start(adc_start), .adc_power_en(adc_power_en),
  .shunt_gain_setting(shunt_gain_setting), .bus_range_sel(bus_range_sel));

// File: tb/tb.sv
/* Self-checking testbench: AHB-Lite master tasks, ADC model, scenario list.
   Assumes the design package, the design and the ADC model are compiled. */
`timescale 1ns/1ps
module tb;
  import shunt_seq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic conv_trigger = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [15:0] shunt_v = 16'h0100;
  logic [15:0] bus_v = 16'h0200;
  logic hreadyout, hresp, irq, adc_start, adc_chan, adc_power_en, adc_done, bus_range_sel;
  logic [1:0] adc_res, gain;
  logic [15:0] adc_data;
  logic [31:0] hrdata, rd;
  int err_total = 0;
  int num_checks = 0;
  int n_start = 0;
  int n;
  always #20 hclk = ~hclk;
  always @(posedge hclk) if (adc_start === 1'b1) n_start++;
  shunt_bus_conversion_sequencer i_shunt_bus_conversion_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .conv_trigger(conv_trigger), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_power_en(adc_power_en), .adc_res(adc_res), .adc_done(adc_done),
    .adc_data(adc_data), .shunt_gain_setting(gain), .bus_range_sel(bus_range_sel));
  adc_model i_adc_model (.clk(hclk), .rst_n(hresetn), .start(adc_start), .chan(adc_chan),
    .lat(lat), .shunt_v(shunt_v), .bus_v(bus_v), .done(adc_done), .data(adc_data));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h1);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(OFF_CONFIG, 32'h399f, "config");
    chk("gain", {30'h0, gain}, 32'h3);
    chk("range", {31'h0, bus_range_sel}, 32'h1);
    xfer(1'b1, OFF_IRQ_MASK, 32'h1);
    wait_irq;
    rdc(OFF_SHUNT, 32'h100, "shunt");
    rdc(OFF_BUS, 32'h200, "bus");
    rdc(OFF_CURRENT, 32'h0, "current");
    lat <= 4'ha;
    xfer(1'b1, OFF_CONFIG, 32'h399b);
    xfer(1'b1, OFF_IRQ_STAT, 32'h1);
    xfer(1'b1, OFF_CAL, 32'h1000);
    wait_irq;
    rdc(OFF_CURRENT, 32'h100, "current");
    rdc(OFF_POWER, 32'h1a, "power");
    rdc(OFF_STATUS, 32'h1, "status");
    rdc(OFF_STATUS, 32'h0, "status");
    n = n_start;
    repeat (40) @(posedge hclk);
    chk("starts", n_start - n, 32'h0);
    xfer(1'b1, OFF_IRQ_STAT, 32'h1);
    shunt_v <= 16'h0200;
    xfer(1'b1, OFF_CONFIG, 32'h399b);
    wait_irq;
    rdc(OFF_SHUNT, 32'h200, "shunt");
    xfer(1'b1, OFF_CONFIG, 32'h399c);
    // Let the write land before the status read samples
    @(posedge hclk);
    rdc(OFF_STATUS, 32'h1, "status");
    n = n_start;
    repeat (40) @(posedge hclk);
    chk("starts", n_start - n, 32'h0);
    xfer(1'b1, OFF_IRQ_STAT, 32'h1);
    bus_v <= 16'h0300;
    xfer(1'b1, OFF_CONFIG, 32'h399a);
    // Write lands, then the sequencer leaves idle one edge later
    repeat (2) @(posedge hclk);
    rdc(OFF_STATUS, 32'h2, "status");
    wait_irq;
    rdc(OFF_BUS, 32'h300, "bus");
    rdc(OFF_SHUNT, 32'h200, "shunt");
    lat <= 4'hf;
    xfer(1'b1, OFF_IRQ_MASK, 32'h0);
    conv_trigger <= 1'b1;
    repeat (3) @(posedge hclk);
    conv_trigger <= 1'b0;
    repeat (6) @(posedge hclk);
    rdc(OFF_STATUS, 32'h2, "status");
    chk("masked irq", {31'h0, irq}, 32'h0);
    xfer(1'b1, OFF_IRQ_STAT, 32'h1);
    xfer(1'b1, OFF_IRQ_MASK, 32'h1);
    wait_irq;
    for (int g = 0; g < 4; g++) begin
      xfer(1'b1, OFF_CONFIG, {18'h0, g[0], g[1:0], 8'h33, 3'h4});
      repeat (2) @(posedge hclk);
      chk("gain", {30'h0, gain}, g);
      chk("range", {31'h0, bus_range_sel}, g % 2);
    end
    xfer(1'b1, OFF_CONFIG, 32'h3998);
    repeat (2) @(posedge hclk);
    chk("power", {31'h0, adc_power_en}, 32'h0);
    xfer(1'b1, OFF_CONFIG, 32'h399f);
    n = 0;
    while (adc_start !== 1'b1 && n < 1500) begin
      @(posedge hclk);
      n++;
    end
    chk("wake", 32'(n >= 1000), 32'h1);
    rdc(8'h40, 32'h0, "unmapped");
    print_verdict;
  end
endmodule
